// >>> src/sgotr_pkg.sv
package sgotr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SGOTR_GATE_OFF = 8'h5c;
  localparam logic [7:0] SGOTR_TRIM_OFF = 8'h60;
  localparam logic [7:0] SGOTR_RTC_OFF = 8'h80;
  localparam logic [7:0] SGOTR_IRQ_STAT_OFF = 8'h64;
  localparam logic [7:0] SGOTR_IRQ_MASK_OFF = 8'h68;

  // ----------------------------------------
  // Field positions, reset values and the fast divider limit
  // ----------------------------------------
  localparam int SGOTR_TRIM_SRC_BIT = 26;
  localparam int SGOTR_TRIM_MAN_BIT = 25;
  localparam int SGOTR_TRIM_START_BIT = 0;
  localparam int SGOTR_RTC_RST_BIT = 1;
  localparam logic [7:0] SGOTR_CAL_RST = 8'h80;
  localparam logic [7:0] SGOTR_SCALE_RST = 8'hff;
  localparam logic [6:0] SGOTR_PSCALE_RST = 7'h7f;
  localparam logic [7:0] SGOTR_FAST_DIV_LAST = 8'h7f;

  // ----------------------------------------
  // Trim timing
  // ----------------------------------------
  localparam logic [11:0] SGOTR_TRIM_TARGET = 12'h07a;
  localparam logic [11:0] SGOTR_TRIM_TOL = 12'h001;
  localparam logic [11:0] SGOTR_REF_TIMEOUT = 12'h0800;

  typedef enum logic [2:0] {
    SGOTR_IDLE = 3'b001,
    SGOTR_WAIT = 3'b010,
    SGOTR_MEAS = 3'b100
  } sgotr_trim_st_t;

  typedef struct packed {
    logic [3:0] gate;
    logic trim_src;
    logic [7:0] cal;
    logic [11:0] cnt_fb;
    logic fail;
    logic trim_mismatch_flag;
    sgotr_trim_st_t st;
    logic [11:0] cnt;
    logic ref_d;
    logic cal_dir;
    logic [5:0] cal_amt;
    logic [7:0] scale;
    logic [6:0] pscale;
    logic [1:0] src;
    logic rtc_rst;
    logic count_on;
    logic [7:0] fdiv;
    logic [6:0] pcnt;
    logic [7:0] scnt;
    logic src_d;
    logic tick;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
  } sgotr_state_t;

endpackage

// >>> src/sgotr_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module sgotr_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trim_ref_pin_i,
  input wire logic slow_ext_ref_i,
  input wire logic fast_osc_clk_i,
  input wire logic slow_ext_osc_i,
  input wire logic slow_int_osc_i,
  input wire logic fast_ext_osc_i,
  output logic [3:0] port_sleep_gate_o,
  output logic manual_trim_pulse_o,
  output logic [7:0] osc_cal_o,
  output logic rtc_tick_o,
  output logic rtc_counter_reset_o,
  output logic rtc_count_on_o,
  output logic [5:0] cal_amount_o,
  output logic cal_direction_o,
  output logic irq_o
);

  sgotr_pkg::sgotr_state_t s_r;
  sgotr_pkg::sgotr_state_t s_nxt;
  logic wr;
  logic rd_ok;
  logic ref_sel;
  logic src_clk;
  logic man_nxt;
  logic man_r;
  logic [11:0] diff;
  logic [1:0] ev;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Access phase completes at once; unmapped offsets answer with an error.
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd_ok = (paddr_i == sgotr_pkg::SGOTR_GATE_OFF) | (paddr_i == sgotr_pkg::SGOTR_TRIM_OFF)
               | (paddr_i == sgotr_pkg::SGOTR_RTC_OFF) | (paddr_i == sgotr_pkg::SGOTR_IRQ_STAT_OFF)
               | (paddr_i == sgotr_pkg::SGOTR_IRQ_MASK_OFF);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~rd_ok;
  assign prdata_o = s_r.prdata;

  // Reference for the trim: pin or slow crystal, but a trim only starts with the pin selected.
  assign ref_sel = s_r.trim_src ? slow_ext_ref_i : trim_ref_pin_i;
  assign diff = (s_r.cnt > sgotr_pkg::SGOTR_TRIM_TARGET) ?
                s_r.cnt - sgotr_pkg::SGOTR_TRIM_TARGET : sgotr_pkg::SGOTR_TRIM_TARGET - s_r.cnt;

  // Source clock level for the RTC divider.
  always_comb begin
    unique case (s_r.src)
      2'b00: src_clk = 1'b0;
      2'b01: src_clk = slow_ext_osc_i;
      2'b10: src_clk = slow_int_osc_i;
      default: src_clk = s_r.fdiv[7];
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // All registers, trim engine and divider chain in one pass.
  always_comb begin
    s_nxt = s_r;
    man_nxt = 1'b0;
    ev = 2'b00;
    s_nxt.tick = 1'b0;
    s_nxt.rtc_rst = 1'b0;
    s_nxt.ref_d = ref_sel;
    s_nxt.src_d = src_clk;
    // Read data is loaded only in a read setup cycle and holds until the next one.
    // Reserved read zero.
    if (psel_i & ~penable_i & ~pwrite_i) begin
      unique case (paddr_i)
        sgotr_pkg::SGOTR_GATE_OFF: s_nxt.prdata = {28'h000_0000, s_r.gate};
        sgotr_pkg::SGOTR_TRIM_OFF: s_nxt.prdata = {5'h00, s_r.trim_src, 2'b00, s_r.cal,
          s_r.cnt_fb, s_r.fail, s_r.trim_mismatch_flag, s_r.st != sgotr_pkg::SGOTR_IDLE, 1'b0};
        sgotr_pkg::SGOTR_RTC_OFF: s_nxt.prdata = {1'b0, s_r.cal_dir, s_r.cal_amt, s_r.scale,
          1'b0, s_r.pscale, 4'h0, s_r.src, 1'b0, s_r.count_on};
        sgotr_pkg::SGOTR_IRQ_STAT_OFF: s_nxt.prdata = {30'h0000_0000, s_r.irq_stat};
        sgotr_pkg::SGOTR_IRQ_MASK_OFF: s_nxt.prdata = {30'h0000_0000, s_r.irq_mask};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // Trim engine: count clock cycles with the fast clock high over one reference period.
    unique case (s_r.st)
      sgotr_pkg::SGOTR_IDLE: begin
      end
      sgotr_pkg::SGOTR_WAIT: begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (ref_sel & ~s_r.ref_d) begin
          s_nxt.cnt = 12'h000;
          s_nxt.st = sgotr_pkg::SGOTR_MEAS;
        end else if (s_r.cnt == sgotr_pkg::SGOTR_REF_TIMEOUT) begin
          s_nxt.fail = 1'b1;
          ev[0] = 1'b1;
          s_nxt.st = sgotr_pkg::SGOTR_IDLE;
        end
      end
      sgotr_pkg::SGOTR_MEAS: begin
        if (fast_osc_clk_i) begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
        if (ref_sel & ~s_r.ref_d) begin
          s_nxt.cnt_fb = s_r.cnt;
          s_nxt.trim_mismatch_flag = diff > sgotr_pkg::SGOTR_TRIM_TOL;
          if (s_r.cnt < sgotr_pkg::SGOTR_TRIM_TARGET) begin
            s_nxt.cal = s_r.cal + 8'h01;
          end else if (s_r.cnt > sgotr_pkg::SGOTR_TRIM_TARGET) begin
            s_nxt.cal = s_r.cal - 8'h01;
          end
          ev[0] = 1'b1;
          s_nxt.st = sgotr_pkg::SGOTR_IDLE;
        end
      end
      default: s_nxt.st = sgotr_pkg::SGOTR_IDLE;
    endcase
    s_nxt.fdiv = s_r.fdiv;
    if (fast_ext_osc_i) begin
      // Divide the fast crystal by 256: bit 7 toggles after every 128 cycles with it high.
      s_nxt.fdiv = (s_r.fdiv[6:0] == sgotr_pkg::SGOTR_FAST_DIV_LAST[6:0]) ?
                   {~s_r.fdiv[7], 7'h00} : s_r.fdiv + 8'h01;
    end
    if (src_clk & ~s_r.src_d) begin
      if (s_r.pcnt >= s_r.pscale) begin
        s_nxt.pcnt = 7'h00;
        if (s_r.scnt >= s_r.scale) begin
          s_nxt.scnt = 8'h00;
          s_nxt.tick = s_r.count_on;
          ev[1] = s_r.count_on;
        end else begin
          s_nxt.scnt = s_r.scnt + 8'h01;
        end
      end else begin
        s_nxt.pcnt = s_r.pcnt + 7'h01;
      end
    end
    // Register writes.
    if (wr) begin
      unique case (paddr_i)
        sgotr_pkg::SGOTR_GATE_OFF: begin
          s_nxt.gate = pwdata_i[3:0];
        end
        sgotr_pkg::SGOTR_TRIM_OFF: begin
          s_nxt.trim_src = pwdata_i[sgotr_pkg::SGOTR_TRIM_SRC_BIT];
          s_nxt.cal = pwdata_i[23:16];
          man_nxt = pwdata_i[sgotr_pkg::SGOTR_TRIM_MAN_BIT];
          if (pwdata_i[sgotr_pkg::SGOTR_TRIM_START_BIT] & ~pwdata_i[sgotr_pkg::SGOTR_TRIM_SRC_BIT]
              & (s_r.st == sgotr_pkg::SGOTR_IDLE)) begin
            s_nxt.st = sgotr_pkg::SGOTR_WAIT;
            s_nxt.cnt = 12'h000;
            s_nxt.fail = 1'b0;
            s_nxt.trim_mismatch_flag = 1'b0;
          end
        end
        sgotr_pkg::SGOTR_RTC_OFF: begin
          s_nxt.cal_dir = pwdata_i[30];
          s_nxt.cal_amt = pwdata_i[29:24];
          s_nxt.scale = pwdata_i[23:16];
          s_nxt.pscale = pwdata_i[14:8];
          s_nxt.src = pwdata_i[3:2];
          s_nxt.rtc_rst = pwdata_i[sgotr_pkg::SGOTR_RTC_RST_BIT];
          s_nxt.count_on = pwdata_i[0];
        end
        sgotr_pkg::SGOTR_IRQ_STAT_OFF: begin
          // Write one clears.
          s_nxt.irq_stat = s_r.irq_stat & ~pwdata_i[1:0];
        end
        sgotr_pkg::SGOTR_IRQ_MASK_OFF: s_nxt.irq_mask = pwdata_i[1:0];
        default: begin
        end
      endcase
    end
    // Events are applied last, so a set in the clearing cycle wins.
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset; clock enable freezes everything.
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.cal <= sgotr_pkg::SGOTR_CAL_RST;
      s_r.scale <= sgotr_pkg::SGOTR_SCALE_RST;
      s_r.pscale <= sgotr_pkg::SGOTR_PSCALE_RST;
      s_r.st <= sgotr_pkg::SGOTR_IDLE;
      man_r <= 1'b0;
    end else if (ce_i) begin
      s_r <= s_nxt;
      man_r <= man_nxt;
    end
  end

  // Outputs from flip-flops.
  assign port_sleep_gate_o = s_r.gate;
  assign manual_trim_pulse_o = man_r;
  assign osc_cal_o = s_r.cal;
  assign rtc_tick_o = s_r.tick;
  assign rtc_counter_reset_o = s_r.rtc_rst;
  assign rtc_count_on_o = s_r.count_on;
  assign cal_amount_o = s_r.cal_amt;
  assign cal_direction_o = s_r.cal_dir;
  assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

endmodule

// >>> test/sgotr_chk.sv
`timescale 1ns/1ns
// Watches the register port and the control outputs of the block except irq_o.
module sgotr_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [3:0] port_sleep_gate_o,
  input wire logic manual_trim_pulse_o,
  input wire logic [7:0] osc_cal_o,
  input wire logic rtc_tick_o,
  input wire logic rtc_counter_reset_o,
  input wire logic rtc_count_on_o,
  input wire logic [5:0] cal_amount_o,
  input wire logic cal_direction_o
);
  logic wr;
  logic map;
  // Decodes an accepted write and the mapped offsets.
  assign wr = psel_i & penable_i & pwrite_i & ce_i;
  assign map = paddr_i inside {8'h5c, 8'h60, 8'h64, 8'h68, 8'h80};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_rdy; psel_i && penable_i |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_err; psel_i && penable_i && !map |-> pslverr_o && (pwrite_i || prdata_o == 0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_gate; wr && paddr_i == 8'h5c |=> port_sleep_gate_o == $past(pwdata_i[3:0]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate bits not written");
  property p_man; wr && paddr_i == 8'h60 && pwdata_i[25] |=> manual_trim_pulse_o ##1
    !manual_trim_pulse_o; endproperty
  a_man: assert property (p_man) else $error("manual trim pulse wrong");
  property p_cal; wr && paddr_i == 8'h60 |=> osc_cal_o == $past(pwdata_i[23:16]); endproperty
  a_cal: assert property (p_cal) else $error("calibration not written");
  property p_rrst; wr && paddr_i == 8'h80 && pwdata_i[1] |=> rtc_counter_reset_o ##1
    !rtc_counter_reset_o; endproperty
  a_rrst: assert property (p_rrst) else $error("counter reset pulse wrong");
  property p_rtc; wr && paddr_i == 8'h80 |=> {cal_direction_o, cal_amount_o, rtc_count_on_o}
    == {$past(pwdata_i[30:24]), $past(pwdata_i[0])}; endproperty
  a_rtc: assert property (p_rtc) else $error("rtc control not written");
  property p_tick; !rtc_count_on_o [*2] |-> !rtc_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick while stopped");
  property p_tpul; rtc_tick_o |=> !rtc_tick_o; endproperty
  a_tpul: assert property (p_tpul) else $error("tick longer than a cycle");
  c_rtc: cover property (wr && paddr_i == 8'h80);
  c_tick: cover property (rtc_tick_o);
  c_err: cover property (psel_i && penable_i && pslverr_o);
endmodule

bind sgotr_top sgotr_chk i_chk (.clock_i, .rstn_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_sleep_gate_o,
  .manual_trim_pulse_o, .osc_cal_o, .rtc_tick_o, .rtc_counter_reset_o, .rtc_count_on_o,
  .cal_amount_o, .cal_direction_o);

// >>> test/tb.sv
`timescale 1ns/1ns
module tb;
  logic clock_i = 0, rstn_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00, osc_cal_o, div = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
  logic pready_o, pslverr_o, se, trim_ref_pin_i = 0, slow_ext_ref_i = 0, fast_osc_clk_i = 1;
  logic slow_ext_osc_i = 0, slow_int_osc_i = 0, fast_ext_osc_i = 0, ref_run = 0;
  logic [3:0] port_sleep_gate_o;
  logic manual_trim_pulse_o, rtc_tick_o, rtc_counter_reset_o, rtc_count_on_o;
  logic cal_direction_o, irq_o;
  logic [5:0] cal_amount_o;
  int mismatches = 0, comparisons = 0, n;
  sgotr_top i_dut (.*);
  // Free running clock.
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // Slow sources of eight and sixteen cycles and a gated trim reference of 64 cycles.
  always @(posedge clock_i) begin
    div <= div + 8'h01;
    slow_ext_osc_i <= div[2];
    slow_int_osc_i <= div[3];
    trim_ref_pin_i <= ref_run & div[5];
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer; read data and error are taken at the completing edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    r = prdata_o;
    se = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    #1;
  endtask
  task automatic wait_idle;
    n = 0;
    do begin
      xfer(0, 8'h60, 0);
      n++;
    end while (r[1] !== 1'b0 && n < 3000);
  endtask
  task automatic t_reset;
    xfer(0, 8'h5c, 0);
    chk("gate_rst", 0, r);
    xfer(0, 8'h60, 0);
    chk("trim_rst", 32'h0080_0000, r);
    xfer(0, 8'h80, 0);
    chk("rtc_rst", 32'h00ff_7f00, r);
  endtask
  task automatic t_gate;
    xfer(1, 8'h5c, 32'hffff_ffff);
    chk("gate_o", 4'hf, port_sleep_gate_o);
    xfer(0, 8'h5c, 0);
    chk("gate_reg", 32'h0000_000f, r);
  endtask
  task automatic t_rtc;
    xfer(1, 8'h80, 32'hffff_ffff);
    chk("cnt_rst", 1, rtc_counter_reset_o);
    chk("rtc_out", 8'hff, {cal_direction_o, cal_amount_o, rtc_count_on_o});
    xfer(0, 8'h80, 0);
    chk("rtc_reg", 32'h7fff_7f0d, r);
  endtask
  // Each source with both dividers at two; only the two slow sources run.
  task automatic t_tick;
    for (int s = 0; s < 4; s++) begin
      xfer(1, 8'h80, 32'h0001_0101 | (s << 2));
      repeat (32) @(posedge clock_i);
      n = 0;
      repeat (128) begin
        @(posedge clock_i);
        #1;
        if (rtc_tick_o === 1'b1) n++;
      end
      chk("ticks", (s == 1) ? 4 : ((s == 2) ? 2 : 0), n);
    end
    xfer(0, 8'h64, 0);
    chk("tick_stat", 1, r[1]);
    chk("irq_mask", 0, irq_o);
    xfer(1, 8'h68, 3);
    chk("irq_on", 1, irq_o);
    xfer(1, 8'h64, 3);
    xfer(0, 8'h64, 0);
    chk("stat_clr", 0, r);
    xfer(1, 8'h68, 0);
    chk("irq_off", 0, irq_o);
  endtask
  task automatic t_trim;
    xfer(1, 8'h60, 32'h0480_0001);
    xfer(0, 8'h60, 0);
    chk("src_ext", 32'h0480_0000, r);
    xfer(1, 8'h60, 32'h0080_0001);
    xfer(0, 8'h60, 0);
    chk("busy", 1, r[1]);
    wait_idle();
    chk("fail", 4, r[3:1]);
    ref_run = 1;
    xfer(1, 8'h60, 32'h0080_0001);
    wait_idle();
    chk("mism", 2, r[3:1]);
    chk("cnt_fb", 12'h03f, r[15:4]);
    chk("cal_move", 8'h81, osc_cal_o);
    xfer(0, 8'h64, 0);
    chk("done_stat", 1, r[0]);
    xfer(1, 8'h64, 1);
    xfer(1, 8'h60, 32'h0255_0000);
    chk("manual", 1, manual_trim_pulse_o);
    chk("cal_wr", 8'h55, osc_cal_o);
  endtask
  task automatic t_unmap;
    xfer(1, 8'h40, 32'hffff_ffff);
    xfer(0, 8'h40, 0);
    chk("unmap_rd", 0, r);
    chk("unmap_err", 1, se);
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1;
    t_reset();
    t_gate();
    t_rtc();
    t_tick();
    t_trim();
    t_unmap();
    finish_test();
  end
  // Cuts a hang short.
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule
